// ===== bench/test_data_eeprom_access_ctrl.sv
// self-checking bench for the nonvolatile access controller
// assumes nv_access_pkg and nv_access_ctrl are compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_data_eeprom_access_ctrl;
  // shortened counts keep the run under a thousand cycles
  localparam int PU_CYC = 200;
  localparam int WR_CYC = 12;
  localparam int LIMIT  = 8000;
  localparam logic [7:0] A_ADL = nv_access_pkg::OFS_ADDR_LOW;
  localparam logic [7:0] A_DTL = nv_access_pkg::OFS_DATA_LOW;
  localparam logic [7:0] A_DTH = nv_access_pkg::OFS_DATA_HIGH;
  localparam logic [7:0] A_CTL = nv_access_pkg::OFS_CONTROL;
  localparam logic [7:0] A_KEY = nv_access_pkg::OFS_UNLOCK;
  localparam logic [7:0] A_STA = nv_access_pkg::OFS_STATUS;
  localparam int B_DONE = nv_access_pkg::STAT_DONE;
  localparam int B_BUSY = nv_access_pkg::STAT_BUSY;
  localparam int B_PWR  = nv_access_pkg::STAT_PWRUP;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_reset;
  logic        data_protect_fuse;
  logic [1:0]  flash_write_protect_field;
  logic [7:0]  ext_prog_addr;
  logic [7:0]  ext_prog_data;
  logic        write_busy;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          samples_checked;
  int          cycles;
  int          busy_cycles;

  nv_access_ctrl #(
    .POWERUP_CYCLES(PU_CYC),
    .WRITE_CYCLES  (WR_CYC)
  ) i_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .cpu_reset                (cpu_reset),
    .data_protect_fuse        (data_protect_fuse),
    .flash_write_protect_field(flash_write_protect_field),
    .ext_prog_addr            (ext_prog_addr),
    .ext_prog_data            (ext_prog_data),
    .write_busy               (write_busy)
  );

  always #2 pclk = ~pclk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // cycle ceiling also counts how long the write timer holds busy
  always @(posedge pclk)
  begin
    cycles++;
    if (write_busy === 1'b1)
      busy_cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; the bench timeout catches a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic keys_and_start(input logic [31:0] ctl);
    apb(1'b1, A_KEY, {24'h0, nv_access_pkg::KEY_FIRST});
    apb(1'b1, A_KEY, {24'h0, nv_access_pkg::KEY_SECOND});
    apb(1'b1, A_CTL, ctl);
  endtask

  task automatic byte_write(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, A_ADL, {24'h0, a});
    apb(1'b1, A_DTL, {24'h0, d});
    apb(1'b1, A_CTL, 32'h04);
    keys_and_start(32'h06);
  endtask

  task automatic byte_read(input logic [7:0] a);
    apb(1'b1, A_ADL, {24'h0, a});
    apb(1'b1, A_CTL, 32'h01);
    apb(1'b0, A_DTL, 32'h0);
  endtask

  // polls status until the given bit drops, bounded
  task automatic poll_clear(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_STA, 32'h0);
      n++;
    end
    while (rd[b] !== 1'b0 && n < 100);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_reset = 1'b0;
    data_protect_fuse = 1'b1;
    flash_write_protect_field = 2'b11;
    ext_prog_addr = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    busy_cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("control", 32'h00, rd)
    apb(1'b0, A_STA, 32'h0);
    `CHECK("hold", 1'b1, rd[B_PWR])
    byte_write(8'hFF, 8'h3C);
    `CHECK("busy", 1'b0, write_busy)
    poll_clear(B_PWR);
    `CHECK("hold", 1'b0, rd[B_PWR])
    $display("test power-up done");
    apb(1'b1, A_CTL, 32'h00);
    keys_and_start(32'h06);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("control", 32'h04, rd)
    $display("test permit done");
    busy_cycles = 0;
    byte_write(8'hFF, 8'hA5);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("strobe", 1'b1, rd[1])
    apb(1'b1, A_CTL, 32'h00);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("strobe", 1'b1, rd[1])
    poll_clear(B_BUSY);
    `CHECK("busy cycles", WR_CYC, busy_cycles)
    `CHECK("done", 1'b1, rd[B_DONE])
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("control", 32'h00, rd)
    apb(1'b1, A_STA, 32'h1);
    apb(1'b0, A_STA, 32'h0);
    `CHECK("done", 1'b0, rd[B_DONE])
    data_protect_fuse <= 1'b0;
    byte_read(8'hFF);
    `CHECK("read", 32'hA5, rd)
    apb(1'b1, A_DTL, 32'h5A);
    apb(1'b0, A_ADL, 32'h0);
    apb(1'b0, A_DTL, 32'h0);
    `CHECK("data low", 32'h5A, rd)
    $display("test write and read done");
    byte_write(8'h00, 8'h11);
    poll_clear(B_BUSY);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("permit kept", 1'b1, rd[2])
    // a second start without fresh keys must be refused
    apb(1'b1, A_CTL, 32'h06);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("strobe", 1'b0, rd[1])
    for (int k = 0; k < 3; k++)
    begin
      if (k != 0)
        apb(1'b1, A_KEY, 32'h55);
      if (k == 1)
        apb(1'b1, A_DTL, 32'h77);
      apb(1'b1, A_KEY, 32'hAA);
      if (k == 2)
        apb(1'b1, A_ADL, 32'h00);
      apb(1'b1, A_CTL, 32'h06);
      apb(1'b0, A_CTL, 32'h0);
      `CHECK("strobe", 1'b0, rd[1])
    end
    byte_read(8'h00);
    `CHECK("read", 32'h11, rd)
    $display("test unlock order done");
    data_protect_fuse <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHECK("prog port", 8'h11, ext_prog_data)
    data_protect_fuse <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHECK("prog port", 8'h00, ext_prog_data)
    $display("test fuse done");
    byte_write(8'h00, 8'h99);
    @(posedge pclk);
    cpu_reset <= 1'b1;
    @(posedge pclk);
    cpu_reset <= 1'b0;
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("control", 32'h08, rd)
    `CHECK("busy", 1'b0, write_busy)
    byte_read(8'h00);
    `CHECK("read", 32'h11, rd)
    $display("test warm reset done");
    apb(1'b0, 8'h1C, 32'h0);
    `CHECK("slverr", 1'b1, err)
    `CHECK("unmapped", 32'h0, rd)
    apb(1'b0, A_KEY, 32'h0);
    `CHECK("key read", 32'h0, rd)
    $display("test map done");
    flash_write_protect_field <= 2'b00;
    apb(1'b1, A_ADL, 32'h00);
    apb(1'b1, A_CTL, 32'h94);
    keys_and_start(32'h96);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("strobe", 1'b0, rd[1])
    flash_write_protect_field <= 2'b11;
    keys_and_start(32'h96);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("strobe", 1'b1, rd[1])
    poll_clear(B_BUSY);
    apb(1'b0, A_CTL, 32'h0);
    `CHECK("row erase", 1'b0, rd[4])
    $display("test flash protect done");
    apb(1'b1, A_ADL, 32'h00);
    apb(1'b1, A_DTL, 32'h34);
    apb(1'b1, A_DTH, 32'h12);
    apb(1'b1, A_CTL, 32'hA4);
    keys_and_start(32'hA6);
    `CHECK("busy", 1'b0, write_busy)
    apb(1'b1, A_ADL, 32'h01);
    apb(1'b1, A_DTL, 32'h78);
    apb(1'b1, A_DTH, 32'h16);
    apb(1'b1, A_CTL, 32'h84);
    keys_and_start(32'h86);
    poll_clear(B_BUSY);
    apb(1'b1, A_ADL, 32'h00);
    apb(1'b1, A_CTL, 32'h81);
    apb(1'b0, A_DTH, 32'h0);
    `CHECK("flash high", 32'h12, rd)
    apb(1'b0, A_DTL, 32'h0);
    `CHECK("flash low", 32'h34, rd)
    apb(1'b1, A_ADL, 32'h01);
    apb(1'b1, A_CTL, 32'h81);
    apb(1'b0, A_DTL, 32'h0);
    `CHECK("flash low", 32'h78, rd)
    apb(1'b1, A_ADL, 32'h02);
    apb(1'b1, A_CTL, 32'h81);
    apb(1'b0, A_DTH, 32'h0);
    `CHECK("flash high", 32'h3F, rd)
    $display("test flash program done");
    wrap_up();
  end
endmodule // test_data_eeprom_access_ctrl
`default_nettype wire

// ===== core/nv_access_ctrl.sv
// APB controller for a 256-byte data EEPROM and a small program flash
// assumes APB master on pclk; fuse, protect field, cpu_reset and the
// programmer port come from logic on pclk
`timescale 1ns/100ps
`default_nettype none
module nv_access_ctrl #(
  parameter int POWERUP_CYCLES = nv_access_pkg::POWERUP_CYCLES,
  parameter int WRITE_CYCLES   = nv_access_pkg::WRITE_CYCLES_DFLT,
  parameter int FLASH_DEPTH    = nv_access_pkg::FLASH_DEPTH_DFLT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output var  logic        pslverr,
  input  wire logic        cpu_reset,
  input  wire logic        data_protect_fuse,
  input  wire logic [1:0]  flash_write_protect_field,
  input  wire logic [7:0]  ext_prog_addr,
  output var  logic [7:0]  ext_prog_data,
  output var  logic        write_busy
);
  localparam int FA = $clog2(FLASH_DEPTH);

  nv_access_pkg::ctrl_s   ctrl;
  nv_access_pkg::unlock_e unlock;
  nv_access_pkg::op_e     op;
  nv_access_pkg::kind_e   op_kind;
  logic [7:0]  nv_addr_low;
  logic [6:0]  nv_addr_high;
  logic [7:0]  nv_data_low;
  logic [5:0]  nv_data_high;
  logic        write_done_flag;
  logic [14:0] op_addr;
  logic [7:0]  op_byte;
  logic [nv_access_pkg::PU_CNT_W-1:0] pu_cnt;
  logic [nv_access_pkg::WR_CNT_W-1:0] wr_cnt;
  logic [7:0]  eeprom [256];
  logic [13:0] flash  [FLASH_DEPTH];
  logic [13:0] latches [nv_access_pkg::LATCH_WORDS];

  // decode
  wire wr_acc   = psel & penable & pwrite;
  wire hit_al   = paddr == nv_access_pkg::OFS_ADDR_LOW;
  wire hit_ah   = paddr == nv_access_pkg::OFS_ADDR_HIGH;
  wire hit_dl   = paddr == nv_access_pkg::OFS_DATA_LOW;
  wire hit_dh   = paddr == nv_access_pkg::OFS_DATA_HIGH;
  wire hit_ct   = paddr == nv_access_pkg::OFS_CONTROL;
  wire hit_key  = paddr == nv_access_pkg::OFS_UNLOCK;
  wire hit_st   = paddr == nv_access_pkg::OFS_STATUS;
  wire hit_any  = hit_al | hit_ah | hit_dl | hit_dh | hit_ct | hit_key
                | hit_st;
  wire ct_write = wr_acc & hit_ct;
  nv_access_pkg::ctrl_s wctrl;
  assign wctrl = nv_access_pkg::ctrl_s'(pwdata[7:0]);

  wire [14:0] full_addr = {nv_addr_high, nv_addr_low};
  wire [13:0] flash_word = flash[full_addr[FA-1:0]];
  wire [7:0]  eeprom_byte = eeprom[nv_addr_low];
  wire [13:0] staged_word = {nv_data_high, nv_data_low};

  logic [15:0] prot_limit;
  assign prot_limit =
    flash_write_protect_field == 2'b00 ? nv_access_pkg::PROT_LIMIT_00 :
    flash_write_protect_field == 2'b01 ? nv_access_pkg::PROT_LIMIT_01 :
    flash_write_protect_field == 2'b10 ? nv_access_pkg::PROT_LIMIT_10 :
                                         nv_access_pkg::PROT_LIMIT_11;
  wire flash_prot = {1'b0, full_addr} < prot_limit;

  wire pwrup_busy = pu_cnt != '0;
  wire read_fire  = ct_write & wctrl.read_strobe;
  wire read_data  = read_fire & ~wctrl.program_space_select
                  & ~wctrl.config_space_select;
  wire read_flash = read_fire & wctrl.program_space_select
                  & ~wctrl.config_space_select;

  // write start: armed key, permit already set, no power-up hold
  wire start_ok = ct_write & wctrl.write_strobe
                & unlock == nv_access_pkg::UNLOCK_ARMED
                & ctrl.write_permit
                & ~pwrup_busy
                & op == nv_access_pkg::OP_IDLE
                & ~wctrl.config_space_select
                & ~(wctrl.program_space_select & flash_prot);
  wire latch_load = start_ok & wctrl.program_space_select
                  & ~wctrl.row_erase;
  wire go_busy  = start_ok & ~(latch_load & wctrl.latch_only);
  wire finish   = op == nv_access_pkg::OP_BUSY & wr_cnt == 1
                & ~cpu_reset;
  wire done_clr = wr_acc & hit_st & pwdata[nv_access_pkg::STAT_DONE];

  nv_access_pkg::kind_e next_kind;
  assign next_kind = ~wctrl.program_space_select ? nv_access_pkg::KIND_DATA
                   : wctrl.row_erase ? nv_access_pkg::KIND_ERASE
                   : nv_access_pkg::KIND_PROG;

  nv_access_pkg::unlock_e next_unlock;
  assign next_unlock =
    ~wr_acc ? unlock
    : ~hit_key ? nv_access_pkg::UNLOCK_IDLE
    : pwdata[7:0] == nv_access_pkg::KEY_FIRST ? nv_access_pkg::UNLOCK_FIRST
    : (pwdata[7:0] == nv_access_pkg::KEY_SECOND
       & unlock == nv_access_pkg::UNLOCK_FIRST)
      ? nv_access_pkg::UNLOCK_ARMED
      : nv_access_pkg::UNLOCK_IDLE;

  wire [31:0] rdata_mux =
      hit_al ? {24'h000000, nv_addr_low}
    : hit_ah ? {25'h0000000, nv_addr_high}
    : hit_dl ? {24'h000000, nv_data_low}
    : hit_dh ? {26'h0000000, nv_data_high}
    : hit_ct ? {24'h000000, ctrl}
    : hit_st ? {29'h00000000, pwrup_busy, write_busy, write_done_flag}
    : 32'h00000000;

  // data is staged during setup so the access phase never stalls
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel & ~penable)
    begin
      prdata  <= rdata_mux;
      pslverr <= ~hit_any;
    end
  end

  // power-up hold only restarts on presetn, not on cpu_reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pu_cnt <= nv_access_pkg::PU_CNT_W'(POWERUP_CYCLES);
    else if (pwrup_busy)
      pu_cnt <= pu_cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unlock <= nv_access_pkg::UNLOCK_IDLE;
    else if (cpu_reset)
      unlock <= nv_access_pkg::UNLOCK_IDLE;
    else
      unlock <= next_unlock;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_addr_low  <= 8'h00;
      nv_addr_high <= 7'h00;
    end
    else if (cpu_reset)
    begin
      nv_addr_low  <= 8'h00;
      nv_addr_high <= 7'h00;
    end
    else if (wr_acc & hit_al)
      nv_addr_low <= pwdata[7:0];
    else if (wr_acc & hit_ah)
      nv_addr_high <= pwdata[6:0];
  end

  // read result lands at the strobe's own edge: visible next cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_data_low  <= 8'h00;
      nv_data_high <= 6'h00;
    end
    else if (read_data)
      nv_data_low <= eeprom_byte;
    else if (read_flash)
      {nv_data_high, nv_data_low} <= flash_word;
    else if (wr_acc & hit_dl)
      nv_data_low <= pwdata[7:0];
    else if (wr_acc & hit_dh)
      nv_data_high <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= nv_access_pkg::CTRL_RESET;
    else if (cpu_reset)
    begin
      ctrl <= nv_access_pkg::CTRL_RESET;
      ctrl.write_abort_error <= ctrl.write_abort_error
                              | op == nv_access_pkg::OP_BUSY;
    end
    else if (ct_write)
    begin
      ctrl.program_space_select <= wctrl.program_space_select;
      ctrl.config_space_select  <= wctrl.config_space_select;
      ctrl.latch_only           <= wctrl.latch_only;
      ctrl.row_erase            <= wctrl.row_erase;
      ctrl.write_abort_error    <= wctrl.write_abort_error;
      ctrl.write_permit         <= wctrl.write_permit;
      ctrl.read_strobe          <= wctrl.read_strobe;
      ctrl.write_strobe         <= ctrl.write_strobe | go_busy;
    end
    else
    begin
      ctrl.read_strobe <= 1'b0;
      if (finish)
      begin
        ctrl.write_strobe <= 1'b0;
        if (op_kind == nv_access_pkg::KIND_ERASE)
          ctrl.row_erase <= 1'b0;
      end
    end
  end

  // op runs to the end whatever happens to write_permit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op      <= nv_access_pkg::OP_IDLE;
      wr_cnt  <= '0;
      op_kind <= nv_access_pkg::KIND_DATA;
      op_addr <= 15'h0000;
      op_byte <= 8'h00;
    end
    else if (cpu_reset)
      op <= nv_access_pkg::OP_IDLE;
    else if (go_busy)
    begin
      op      <= nv_access_pkg::OP_BUSY;
      wr_cnt  <= nv_access_pkg::WR_CNT_W'(WRITE_CYCLES);
      op_kind <= next_kind;
      op_addr <= full_addr;
      op_byte <= nv_data_low;
    end
    else if (op == nv_access_pkg::OP_BUSY)
    begin
      wr_cnt <= wr_cnt - 1'b1;
      if (finish)
        op <= nv_access_pkg::OP_IDLE;
    end
  end
  assign write_busy = op == nv_access_pkg::OP_BUSY;

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      write_done_flag <= 1'b0;
    else
      write_done_flag <= (write_done_flag & ~done_clr) | finish;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < nv_access_pkg::LATCH_WORDS; i++)
        latches[i] <= nv_access_pkg::ERASED_WORD;
    else if (finish & op_kind == nv_access_pkg::KIND_PROG)
      for (int i = 0; i < nv_access_pkg::LATCH_WORDS; i++)
        latches[i] <= nv_access_pkg::ERASED_WORD;
    else if (latch_load)
      latches[full_addr[nv_access_pkg::LATCH_BITS-1:0]] <= staged_word;
  end

  // arrays are nonvolatile: no reset
  always_ff @(posedge pclk)
  begin
    if (finish & op_kind == nv_access_pkg::KIND_DATA)
      eeprom[op_addr[7:0]] <= op_byte;
    if (finish & op_kind == nv_access_pkg::KIND_ERASE)
      for (int i = 0; i < nv_access_pkg::ROW_WORDS; i++)
        flash[{op_addr[FA-1:nv_access_pkg::ROW_BITS],
               nv_access_pkg::ROW_BITS'(i)}]
          <= nv_access_pkg::ERASED_WORD;
    if (finish & op_kind == nv_access_pkg::KIND_PROG)
      for (int i = 0; i < nv_access_pkg::LATCH_WORDS; i++)
        flash[{op_addr[FA-1:nv_access_pkg::LATCH_BITS],
               nv_access_pkg::LATCH_BITS'(i)}] <= latches[i];
  end

  // programmer sees zeros while the data protect fuse is at 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_prog_data <= 8'h00;
    else
      ext_prog_data <= data_protect_fuse
                     ? eeprom[ext_prog_addr] : 8'h00;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write_start;
    $rose(ctrl.write_strobe);
  endsequence

  sequence s_data_read;
    read_data ##1 1'b1;
  endsequence

  a_read_next_cycle: assert property (
    read_data |=> nv_data_low == $past(eeprom_byte))
    else $error("read byte not in data low next cycle");

  a_read_strobe_drop: assert property (
    s_data_read |-> ##1 (~ctrl.read_strobe | $past(read_fire)))
    else $error("read strobe not cleared");

  a_unlock_order: assert property (
    s_write_start |-> $past(unlock) == nv_access_pkg::UNLOCK_ARMED)
    else $error("write started without unlock sequence");

  a_permit_first: assert property (
    s_write_start |-> $past(ctrl.write_permit) & ~$past(pwrup_busy))
    else $error("write started without permit");

  a_permit_held: assert property (
    ctrl.write_permit & ~ct_write & ~cpu_reset |=> ctrl.write_permit)
    else $error("write permit cleared by hardware");

  a_strobe_held: assert property (
    write_busy & wr_cnt > 1 & ~cpu_reset |=> ctrl.write_strobe & write_busy)
    else $error("write ended before count expired");

  a_done_on_finish: assert property (
    finish |=> write_done_flag & ~ctrl.write_strobe)
    else $error("finish did not set done and clear strobe");

  a_done_sticky: assert property (
    write_done_flag & ~done_clr |=> write_done_flag)
    else $error("done flag dropped without software clear");

  a_pwrup_block: assert property (
    pwrup_busy |=> ~$rose(ctrl.write_strobe))
    else $error("write started during power-up hold");

  a_fuse_hides: assert property (
    ~data_protect_fuse |=> ext_prog_data == 8'h00)
    else $error("protected data leaked to programmer");

  a_prot_segment: assert property (
    s_write_start |-> ~($past(wctrl.program_space_select)
      & $past(flash_prot)))
    else $error("flash write into protected segment");

  a_abort_error: assert property (
    cpu_reset & write_busy |=> ctrl.write_abort_error & ~write_busy)
    else $error("aborted write not flagged");

endmodule // nv_access_ctrl
`default_nettype wire

// ===== core/nv_access_pkg.sv
// constants, types and register map of the nonvolatile access controller
// assumes a 250 MHz APB clock and a byte-wide register view
package nv_access_pkg;

  localparam int CLK_PERIOD_NS     = 4;
  localparam int POWERUP_TIME_MS   = 64;
  localparam int POWERUP_CYCLES    =
    POWERUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PU_CNT_W          = 24;
  localparam int WRITE_CYCLES_DFLT = 64;
  localparam int WR_CNT_W          = 16;
  localparam int FLASH_DEPTH_DFLT  = 512;

  localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_UNLOCK    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int STAT_DONE  = 0;
  localparam int STAT_BUSY  = 1;
  localparam int STAT_PWRUP = 2;

  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam int ROW_WORDS   = 32;
  localparam int ROW_BITS    = 5;
  localparam int LATCH_WORDS = 8;
  localparam int LATCH_BITS  = 3;

  // first unprotected word address per protect field value
  localparam logic [15:0] PROT_LIMIT_00 = 16'h8000;
  localparam logic [15:0] PROT_LIMIT_01 = 16'h1000;
  localparam logic [15:0] PROT_LIMIT_10 = 16'h0200;
  localparam logic [15:0] PROT_LIMIT_11 = 16'h0000;

  typedef struct packed {
    logic program_space_select;
    logic config_space_select;
    logic latch_only;
    logic row_erase;
    logic write_abort_error;
    logic write_permit;
    logic write_strobe;
    logic read_strobe;
  } ctrl_s;

  typedef enum logic [1:0] {
    UNLOCK_IDLE  = 2'b00,
    UNLOCK_FIRST = 2'b01,
    UNLOCK_ARMED = 2'b11
  } unlock_e;

  typedef enum logic {
    OP_IDLE = 1'b0,
    OP_BUSY = 1'b1
  } op_e;

  typedef enum logic [1:0] {
    KIND_DATA  = 2'b00,
    KIND_ERASE = 2'b01,
    KIND_PROG  = 2'b11
  } kind_e;

endpackage
